/* File: shadowed_register_channel_index.sv */
`timescale 1ns/1ps
`default_nettype none
module shadowed_register_channel_index
   import shadow_regs_pkg::*;
#(
   parameter logic [7:0] PART_ID     = PART_ID_DEFAULT,
   parameter logic [1:0] SPEED_GRADE = SPEED_GRADE_DEF
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Serial control port
   input  wire logic  sclk,
   input  wire logic  csb_n,
   input  wire logic  sdio_in,
   output logic       sdio_out,
   output logic       sdio_oe_n,
   // Configuration status
   output logic       lsb_first,
   output logic       soft_reset,
   output logic       commit_pulse,
   // Operating configuration, per channel
   output var logic [7:0] active_cfg [CHANNELS][SHADOW_COUNT]
);

   // ----------------------------------------------------------------
   // Serial clock edges
   // ----------------------------------------------------------------
   logic        sclk_prev_reg;
   logic        rise;
   logic        fall;
   phase_type   phase_reg;
   logic [3:0]  bit_cnt_reg;
   logic [15:0] instr_reg;
   logic        is_read_reg;
   logic [1:0]  words_reg;
   logic [1:0]  byte_cnt_reg;
   logic [7:0]  addr_reg;
   logic [7:0]  rx_reg;
   logic [7:0]  tx_reg;
   logic        fresh_reg;
   logic [15:0] instr_shift;
   logic [15:0] instr_word;
   logic [7:0]  rx_shift;
   logic [7:0]  rx_byte;
   logic [7:0]  next_addr;
   logic        last_byte;
   logic        wr_reg;
   logic        rd_reg;
   logic [7:0]  acc_addr_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  rdata;
   logic [1:0]  chan_sel_reg;
   logic        lsb_first_reg;
   logic        soft_reset_reg;
   logic        commit_reg;
   logic        in_shadow;
   logic        acc_local;
   logic [7:0]  stage_q [CHANNELS];

   // Previous serial clock level
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk;
      end
   end
   assign rise = ~csb_n & sclk & ~sclk_prev_reg;
   assign fall = ~csb_n & ~sclk & sclk_prev_reg;

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   // shift in from the top in LSB-first order, so words land unreversed
   assign instr_shift = lsb_first_reg ? {sdio_in, instr_reg[15:1]} : {instr_reg[14:0], sdio_in};
   assign instr_word  = instr_shift;
   assign rx_shift    = lsb_first_reg ? {sdio_in, rx_reg[7:1]} : {rx_reg[6:0], sdio_in};
   assign rx_byte     = rx_shift;
   assign next_addr   = lsb_first_reg ? addr_reg + ADDR_STEP : addr_reg - ADDR_STEP;
   assign last_byte   = (words_reg != WORDS_STREAM) && (byte_cnt_reg == words_reg);

   // Instruction and data phase sequencing
   always_ff @(posedge clk) begin
      if (rst || csb_n) begin
         phase_reg    <= PH_INSTR;
         bit_cnt_reg  <= '0;
         instr_reg    <= '0;
         rx_reg       <= '0;
         is_read_reg  <= 1'b0;
         words_reg    <= '0;
         byte_cnt_reg <= '0;
         addr_reg     <= '0;
      end else if (rise) begin
         unique case (phase_reg)
            PH_INSTR: begin
               instr_reg <= instr_shift;
               if (bit_cnt_reg == LAST_INSTR_BIT) begin
                  phase_reg    <= PH_DATA;
                  bit_cnt_reg  <= '0;
                  is_read_reg  <= instr_word[INSTR_RW_BIT];
                  words_reg    <= instr_word[INSTR_W_HI:INSTR_W_LO];
                  addr_reg     <= instr_word[7:0];
                  byte_cnt_reg <= '0;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            PH_DATA: begin
               rx_reg <= rx_shift;
               if (bit_cnt_reg == LAST_DATA_BIT) begin
                  bit_cnt_reg  <= '0;
                  addr_reg     <= next_addr;
                  byte_cnt_reg <= byte_cnt_reg + 2'h1;
                  if (last_byte) begin
                     phase_reg <= PH_DONE;
                  end
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            PH_DONE: ;
         endcase
      end
   end

   // Register access strobes, one cycle each
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg       <= 1'b0;
         rd_reg       <= 1'b0;
         acc_addr_reg <= '0;
         wdata_reg    <= '0;
      end else begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         if (rise && phase_reg == PH_INSTR && bit_cnt_reg == LAST_INSTR_BIT
             && instr_word[INSTR_RW_BIT]) begin
            rd_reg       <= 1'b1;
            acc_addr_reg <= instr_word[7:0];
         end else if (rise && phase_reg == PH_DATA && bit_cnt_reg == LAST_DATA_BIT) begin
            if (is_read_reg && !last_byte) begin
               rd_reg       <= 1'b1;
               acc_addr_reg <= next_addr;
            end else if (!is_read_reg) begin
               wr_reg       <= 1'b1;
               acc_addr_reg <= addr_reg;
               wdata_reg    <= rx_byte;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Readback shifter
   // ----------------------------------------------------------------
   // First bit held over the falling edge that follows a load
   always_ff @(posedge clk) begin
      if (rst || csb_n) begin
         tx_reg    <= '0;
         fresh_reg <= 1'b0;
      end else if (rd_reg) begin
         tx_reg    <= rdata;
         fresh_reg <= 1'b1;
      end else if (fall && phase_reg == PH_DATA && is_read_reg) begin
         if (fresh_reg) begin
            fresh_reg <= 1'b0;
         end else begin
            tx_reg <= lsb_first_reg ? (tx_reg >> 1) : (tx_reg << 1);
         end
      end
   end

   assign sdio_out  = lsb_first_reg ? tx_reg[0] : tx_reg[7];
   assign sdio_oe_n = ~(~csb_n && phase_reg == PH_DATA && is_read_reg);
   // ----------------------------------------------------------------
   // Chip configuration registers
   // ----------------------------------------------------------------
   // Channel select, restored by reset or soft reset
   always_ff @(posedge clk) begin
      if (rst || soft_reset_reg) begin
         chan_sel_reg <= CHAN_SEL_RESET;
      end else if (wr_reg && acc_addr_reg == ADDR_CHAN_SEL) begin
         chan_sel_reg <= wdata_reg[CHAN_SEL_W-1:0];
      end
   end

   // Port configuration, mirrored nibbles
   always_ff @(posedge clk) begin
      if (rst || soft_reset_reg) begin
         // default order, soft reset clears itself
         lsb_first_reg  <= 1'b0;
         soft_reset_reg <= 1'b0;
      end else if (wr_reg && acc_addr_reg == ADDR_PORT_CFG
                   && chan_sel_reg == CHAN_SEL_BOTH) begin
         lsb_first_reg  <= wdata_reg[PCFG_LSB_HI] | wdata_reg[PCFG_LSB_LO];
         soft_reset_reg <= wdata_reg[PCFG_SR_HI] | wdata_reg[PCFG_SR_LO];
      end
   end

   // Transfer bit
   always_ff @(posedge clk) begin
      if (rst) begin
         commit_reg <= 1'b0;
      end else if (wr_reg && acc_addr_reg == ADDR_COMMIT && wdata_reg[COMMIT_BIT]) begin
         commit_reg <= 1'b1;
      end else begin
         commit_reg <= 1'b0;
      end
   end

   assign lsb_first    = lsb_first_reg;
   assign soft_reset   = soft_reset_reg;
   assign commit_pulse = commit_reg;
   // ----------------------------------------------------------------
   // Per-channel shadow storage
   // ----------------------------------------------------------------
   assign in_shadow = (acc_addr_reg >= ADDR_SHADOW_LO) && (acc_addr_reg <= ADDR_SHADOW_HI);
   assign acc_local = is_local(acc_addr_reg);

   shadow_store_if store_bus [CHANNELS] ();

   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign store_bus[ch].wr_en   = wr_reg && in_shadow && (!acc_local || chan_sel_reg[ch]);
      assign store_bus[ch].idx     = IDX_W'(acc_addr_reg - ADDR_SHADOW_LO);
      assign store_bus[ch].wdata   = wdata_reg;
      assign store_bus[ch].commit  = commit_reg;
      assign store_bus[ch].restore = soft_reset_reg;
      assign stage_q[ch]           = store_bus[ch].stage_q;

      channel_shadow_store #(
         .COUNT (SHADOW_COUNT)
      ) u_store (
         .clk        (clk),
         .rst        (rst),
         .bus        (store_bus[ch]),
         .active_cfg (active_cfg[ch])
      );
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      rdata = BYTE_ZERO;
      if (in_shadow) begin
         rdata = (acc_local && !chan_sel_reg[0] && chan_sel_reg[1]) ? stage_q[1] : stage_q[0];
      end else begin
         case (acc_addr_reg)
            ADDR_PORT_CFG: begin
               rdata              = PORT_CFG_RESET;
               rdata[PCFG_LSB_HI] = lsb_first_reg;
               rdata[PCFG_LSB_LO] = lsb_first_reg;
               rdata[PCFG_SR_HI]  = soft_reset_reg;
               rdata[PCFG_SR_LO]  = soft_reset_reg;
            end
            ADDR_PART_ID:     rdata = PART_ID;
            ADDR_SPEED_GRADE: rdata[GRADE_LSB +: 2] = SPEED_GRADE;
            ADDR_CHAN_SEL:    rdata[CHAN_SEL_W-1:0] = chan_sel_reg;
            ADDR_COMMIT:      rdata[COMMIT_BIT] = commit_reg;
            default:          rdata = BYTE_ZERO;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: shadow_regs_pkg.sv */
package shadow_regs_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_CFG    = 8'h00;
   localparam logic [7:0] ADDR_PART_ID     = 8'h01;
   localparam logic [7:0] ADDR_SPEED_GRADE = 8'h02;
   localparam logic [7:0] ADDR_CHAN_SEL    = 8'h05;
   localparam logic [7:0] ADDR_COMMIT      = 8'hFF;
   localparam logic [7:0] ADDR_SHADOW_LO   = 8'h08;
   localparam logic [7:0] ADDR_SHADOW_HI   = 8'h79;
   localparam logic [7:0] ADDR_POWER_MODES = 8'h08;
   localparam logic [7:0] ADDR_GLOBAL_CLK  = 8'h09;
   localparam logic [7:0] ADDR_TEST_MODE   = 8'h0D;
   localparam int         SHADOW_COUNT     = 114;
   localparam int         CHANNELS         = 2;
   localparam int         IDX_W            = 7;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_CFG_RESET   = 8'h18;
   localparam logic [1:0] CHAN_SEL_RESET   = 2'h3;
   localparam logic [1:0] CHAN_SEL_BOTH    = 2'h3;
   localparam logic [7:0] GLOBAL_CLK_RESET = 8'h01;
   localparam logic [7:0] BYTE_ZERO        = 8'h00;
   localparam logic [7:0] PART_ID_DEFAULT  = 8'h5A;   // Arbitrary value
   localparam logic [1:0] SPEED_GRADE_DEF  = 2'h0;
   localparam int         PCFG_LSB_HI      = 6;
   localparam int         PCFG_SR_HI       = 5;
   localparam int         PCFG_SR_LO       = 2;
   localparam int         PCFG_LSB_LO      = 1;
   localparam int         GRADE_LSB        = 4;
   localparam int         COMMIT_BIT       = 0;
   localparam int         CHAN_SEL_W       = 2;

   // ----------------------------------------------------------------
   // Serial frame layout
   // ----------------------------------------------------------------
   localparam int         INSTR_RW_BIT     = 15;
   localparam int         INSTR_W_HI       = 14;
   localparam int         INSTR_W_LO       = 13;
   localparam logic [3:0] LAST_INSTR_BIT   = 4'hF;
   localparam logic [3:0] LAST_DATA_BIT    = 4'h7;
   localparam logic [1:0] WORDS_STREAM     = 2'h3;
   localparam logic [7:0] ADDR_STEP        = 8'h01;

   typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} phase_type;

   // Local registers have one copy per channel
   function automatic logic is_local(input logic [7:0] addr);
      return (addr == ADDR_POWER_MODES) || (addr == ADDR_TEST_MODE);
   endfunction

   // Value of a shadowed location after reset
   function automatic logic [7:0] shadow_reset(input int idx);
      return (idx == int'(ADDR_GLOBAL_CLK - ADDR_SHADOW_LO)) ? GLOBAL_CLK_RESET : BYTE_ZERO;
   endfunction

endpackage

/* File: shadow_store_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface shadow_store_if;
   import shadow_regs_pkg::*;

   logic             wr_en;
   logic [IDX_W-1:0] idx;
   logic [7:0]       wdata;
   logic             commit;
   logic             restore;
   logic [7:0]       stage_q;

   modport ctrl  (output wr_en, idx, wdata, commit, restore, input stage_q);
   modport store (input wr_en, idx, wdata, commit, restore, output stage_q);
endinterface
`default_nettype wire

/* File: channel_shadow_store.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_shadow_store
   import shadow_regs_pkg::*;
#(
   parameter int COUNT = SHADOW_COUNT
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Control side
   shadow_store_if.store bus,
   // Operating configuration
   output var logic [7:0] active_cfg [COUNT]
);

   logic [7:0] stage_mem [COUNT];

   // ----------------------------------------------------------------
   // Staging copy
   // ----------------------------------------------------------------
   // Host writes land here only
   always_ff @(posedge clk) begin
      if (rst || bus.restore) begin
         for (int i = 0; i < COUNT; i++) begin
            stage_mem[i] <= shadow_reset(i);
         end
      end else if (bus.wr_en) begin
         stage_mem[bus.idx] <= bus.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Active copy
   // ----------------------------------------------------------------
   // Whole array copied in a single edge
   always_ff @(posedge clk) begin
      if (rst || bus.restore) begin
         for (int i = 0; i < COUNT; i++) begin
            active_cfg[i] <= shadow_reset(i);
         end
      end else if (bus.commit) begin
         for (int i = 0; i < COUNT; i++) begin
            active_cfg[i] <= stage_mem[i];
         end
      end
   end

   // Readback shows the staged value
   assign bus.stage_q = stage_mem[bus.idx];

endmodule
`default_nettype wire

/* File: srci_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module srci_monitor
   import shadow_regs_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Serial port
   input wire logic       sclk,
   input wire logic       csb_n,
   input wire logic       sdio_oe_n,
   // Status
   input wire logic       lsb_first,
   input wire logic       soft_reset,
   input wire logic       commit_pulse,
   input wire logic [7:0] active_cfg [CHANNELS][SHADOW_COUNT]
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Strobes last exactly one cycle
   sequence s_commit_once;
      commit_pulse ##1 !commit_pulse;
   endsequence
   sequence s_reset_once;
      soft_reset ##1 !soft_reset;
   endsequence
   // Active copies move only on a strobe
   sequence s_active_moved;
      !$stable(active_cfg[0][0]) || !$stable(active_cfg[1][0]) || !$stable(active_cfg[0][5]);
   endsequence

   a_commit_self_clear: assert property (commit_pulse |-> s_commit_once)
      else $error("transfer strobe longer than one cycle");
   a_commit_after_rise: assert property (
      commit_pulse |-> $past(sclk, 2) && !$past(sclk, 3) && !$past(csb_n, 2))
      else $error("transfer strobe not two cycles after a serial rise");
   a_active_on_commit: assert property (
      s_active_moved |-> $past(commit_pulse) || $past(soft_reset) || soft_reset)
      else $error("operating value changed without transfer");
   a_global_shared: assert property (
      active_cfg[0][1] == active_cfg[1][1])
      else $error("global location differs between channels");
   a_oe_only_in_frame: assert property (!sdio_oe_n |-> !csb_n)
      else $error("data line driven outside a frame");
   a_soft_self_clear: assert property (soft_reset |-> s_reset_once)
      else $error("soft reset strobe longer than one cycle");
   a_soft_msb_order: assert property (soft_reset |-> ##[1:2] !lsb_first)
      else $error("shift order not restored by soft reset");
   a_reset_idle: assert property (
      $fell(rst) |-> !commit_pulse && !soft_reset && !lsb_first && sdio_oe_n)
      else $error("outputs not idle after reset");
endmodule
`default_nettype wire

/* File: srci_host.sv */
`timescale 1ns/1ps
`default_nettype none
module srci_host (
   // Clock
   input  wire logic clk,
   // Serial lines
   output var logic  sclk,
   output var logic  csb_n,
   output var logic  sdio_host,
   input  wire logic sdio_line
);
   // Idle lines before the first frame
   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdio_host = 1'b0;
   end

   // Host shift order, set by the bench to follow the device
   logic lsb_mode = 1'b0;

   // One frame of one or two bytes; half periods of three or more cycles
   task automatic frame(input logic rd, input logic [7:0] addr, input int n,
                        input logic [15:0] wd, output logic [15:0] got);
      logic [15:0] instr;
      int          j;
      int          b;
      int          k;
      // instruction with word count, then n bytes
      instr = {rd, 2'(n - 1), 5'h00, addr};
      got = 16'h0000;
      @(posedge clk);
      csb_n <= 1'b0;
      // bit order follows the selected shift mode
      for (int p = 0; p < 16 + 8 * n; p++) begin
         j = (p < 16) ? p : (p - 16) % 8;
         b = (p < 16) ? 0 : (p - 16) / 8;
         k = lsb_mode ? j : ((p < 16) ? 15 - j : 7 - j);
         @(posedge clk);
         sclk <= 1'b0;
         if (p >= 16 && rd) begin
            sdio_host <= ~sdio_host; // Released: toggles
         end else begin
            sdio_host <= (p < 16) ? instr[k] : wd[8 * b + k];
         end
         repeat (4) @(posedge clk);
         if (p >= 16) begin
            got[8 * b + k] = sdio_line;
         end
         sclk <= 1'b1;
         repeat (2) @(posedge clk);
      end
      @(posedge clk);
      csb_n <= 1'b1;
      sdio_host <= ~sdio_host;
   endtask
endmodule
`default_nettype wire

/* File: shadowed_register_channel_index_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module shadowed_register_channel_index_tb;
   import shadow_regs_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   wire logic  sclk, csb_n, sdio_host, sdio_line;
   logic       sdio_out, sdio_oe_n, lsb_first, soft_reset, commit_pulse;
   logic [7:0] active_cfg [CHANNELS][SHADOW_COUNT];
   int         err_count = 0;
   int         n_checks = 0;
   int         sr_seen = 0;
   logic [15:0] pair;

   // Clock and shared data line
   always #12.5 clk = ~clk;
   assign sdio_line = sdio_oe_n ? sdio_host : sdio_out;
   always @(posedge clk) if (soft_reset === 1'b1) sr_seen++;

   shadowed_register_channel_index i_dut (.clk(clk), .rst(rst), .sclk(sclk),
      .csb_n(csb_n), .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
      .lsb_first(lsb_first), .soft_reset(soft_reset), .commit_pulse(commit_pulse),
      .active_cfg(active_cfg));
   srci_host i_host (.clk(clk), .sclk(sclk), .csb_n(csb_n), .sdio_host(sdio_host),
      .sdio_line(sdio_line));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] dummy;
      i_host.frame(1'b0, a, 1, {8'h00, d}, dummy);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [15:0] got;
      i_host.frame(1'b1, a, 1, 16'h0000, got);
      check($sformatf("register %h", a), exp, got[7:0]);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      print_verdict();
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rchk(ADDR_PORT_CFG, PORT_CFG_RESET);
      rchk(ADDR_CHAN_SEL, {6'h00, CHAN_SEL_RESET});
      rchk(ADDR_PART_ID, PART_ID_DEFAULT);
      rchk(ADDR_SPEED_GRADE, {2'b00, SPEED_GRADE_DEF, 4'h0});
      wr(ADDR_PART_ID, 8'h00);
      rchk(ADDR_PART_ID, PART_ID_DEFAULT);
      wr(8'h03, 8'h5A);
      rchk(8'h03, 8'h00);
      wr(8'h7A, 8'h33);
      rchk(8'h7A, 8'h00);
      wr(ADDR_GLOBAL_CLK, 8'h5C);
      rchk(ADDR_GLOBAL_CLK, 8'h5C);
      check("active A 09", GLOBAL_CLK_RESET, active_cfg[0][1]);
      // Per-channel copies
      wr(ADDR_CHAN_SEL, 8'h01);
      wr(ADDR_POWER_MODES, 8'h11);
      wr(ADDR_GLOBAL_CLK, 8'h66);
      wr(ADDR_CHAN_SEL, 8'h02);
      wr(ADDR_POWER_MODES, 8'h22);
      rchk(ADDR_POWER_MODES, 8'h22);
      rchk(ADDR_GLOBAL_CLK, 8'h66);
      wr(ADDR_CHAN_SEL, 8'h01);
      rchk(ADDR_POWER_MODES, 8'h11);
      wr(ADDR_CHAN_SEL, 8'h03);
      wr(ADDR_TEST_MODE, 8'h44);
      rchk(ADDR_POWER_MODES, 8'h11);
      wr(ADDR_CHAN_SEL, 8'h02);
      rchk(ADDR_TEST_MODE, 8'h44);
      check("active A 08", 8'h00, active_cfg[0][0]);
      // Transfer
      wr(ADDR_COMMIT, 8'h01);
      repeat (2) @(posedge clk);
      check("active A 08", 8'h11, active_cfg[0][0]);
      check("active B 08", 8'h22, active_cfg[1][0]);
      check("active A 09", 8'h66, active_cfg[0][1]);
      check("active B 09", 8'h66, active_cfg[1][1]);
      check("active A 0d", 8'h44, active_cfg[0][5]);
      check("active B 0d", 8'h44, active_cfg[1][5]);
      rchk(ADDR_COMMIT, 8'h00);
      // Port configuration gated by channel select
      wr(ADDR_CHAN_SEL, 8'h01);
      wr(ADDR_PORT_CFG, 8'h24);
      rchk(ADDR_CHAN_SEL, 8'h01);
      check("soft reset count", 8'h00, 8'(sr_seen));
      wr(ADDR_CHAN_SEL, 8'h03);
      wr(ADDR_PORT_CFG, 8'h24);
      repeat (2) @(posedge clk);
      check("soft reset count", 8'h01, 8'(sr_seen));
      rchk(ADDR_GLOBAL_CLK, GLOBAL_CLK_RESET);
      rchk(ADDR_PORT_CFG, PORT_CFG_RESET);
      check("active A 08", 8'h00, active_cfg[0][0]);
      // Two-byte frames, address steps down
      i_host.frame(1'b0, ADDR_TEST_MODE, 2, 16'hC3A5, pair);
      i_host.frame(1'b1, ADDR_TEST_MODE, 2, 16'h0000, pair);
      check("pair 0d", 8'hA5, pair[7:0]);
      check("pair 0c", 8'hC3, pair[15:8]);
      // LSB-first order, address steps up
      wr(ADDR_PORT_CFG, 8'h42);
      check("lsb first", 8'h01, {7'h00, lsb_first});
      i_host.lsb_mode = 1'b1;
      rchk(ADDR_PORT_CFG, 8'h5A);
      i_host.frame(1'b0, 8'h0A, 2, 16'h6B1E, pair);
      i_host.frame(1'b1, 8'h0A, 2, 16'h0000, pair);
      check("pair 0a", 8'h1E, pair[7:0]);
      check("pair 0b", 8'h6B, pair[15:8]);
      rchk(8'h0B, 8'h6B);
      wr(ADDR_PORT_CFG, 8'h24);
      repeat (2) @(posedge clk);
      i_host.lsb_mode = 1'b0;
      check("lsb first", 8'h00, {7'h00, lsb_first});
      check("soft reset count", 8'h02, 8'(sr_seen));
      rchk(8'h0A, 8'h00);
      print_verdict();
   end
endmodule

bind shadowed_register_channel_index srci_monitor i_mon (.clk(clk), .rst(rst),
   .sclk(sclk), .csb_n(csb_n), .sdio_oe_n(sdio_oe_n), .lsb_first(lsb_first),
   .soft_reset(soft_reset), .commit_pulse(commit_pulse), .active_cfg(active_cfg));
`default_nettype wire
